/* rtl/oamd_decoder.sv */
// Operand address mode decoder: fetches prebyte, opcode, operand and pointer
// bytes and forms the effective address, branch target and next program counter.
// Assumes a memory on the same clock that returns data one cycle after a read.
//
// Function
// - Seventeen addressing modes in seven groups.
// - Short submodes take one address byte; short indexed reaches 1FE.
// - Long submodes reach whole 64 Kbyte space.
// - Read-modify-write opcodes use short submodes only.
// - Inherent instructions are one byte, two with prebyte 90.
// - Immediate: one operand byte after opcode.
// - Short direct: one address byte, page zero.
// - Long direct: 16-bit address from two bytes.
// - Indexed: unsigned sum of index and offset.
// - No-offset indexed: index alone addresses page zero.
// - Short indexed: byte offset, span 00 to 1FE.
// - Long indexed: word offset plus index.
// - Indirect: read operand address at pointer.
// - Short indirect: byte pointer, page zero.
// - Long indirect forms: word pointer, full space.
// - Indirect indexed: pointer value plus index.
// - Short indirect indexed: span 00 to 1FE.
// - Set mask gives level 3, clear level 0.
// - Relative: signed 8-bit offset added to PC.
// - Prebyte 90 selects the second index register.
// - Prebyte 92 indirect; 91 second-register indirect indexed.

`timescale 1ns/1ps

module oamd_decoder
	import oamd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// Decode request
	input  wire logic        start_i,
	input  wire logic [15:0] pc_i,
	input  wire logic [7:0]  x_i,
	input  wire logic [7:0]  y_i,
	// Memory read port
	output logic             mem_rd_o,
	output logic [15:0]      mem_addr_o,
	input  wire logic [7:0]  mem_rdata_i,
	// Decode result
	output logic             busy_o,
	output logic             done_o,
	output logic [4:0]       mode_o,
	output logic [7:0]       opcode_o,
	output logic [7:0]       operand_o,
	output logic [15:0]      ea_o,
	output logic [15:0]      target_o,
	output logic [15:0]      next_pc_o,
	output logic [2:0]       length_o,
	output logic             second_index_o,
	output logic             illegal_o,
	output logic [1:0]       irq_mask_o
);

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic oamd_mode_t dec_mode(input logic [7:0] p, input logic [7:0] o);
		logic ind;
		logic ind_idx;
		ind     = (p == INDIRECT_PREBYTE);
		ind_idx = ind || (p == SECOND_INDIRECT_PREBYTE);
		case (o[7:4])
			GRP_BIT_REL:  dec_mode = ind ? M_BITREL_I : M_BITREL_D;
			GRP_BIT:      dec_mode = ind ? M_BIT_I : M_BIT_D;
			GRP_REL:      dec_mode = ind ? M_REL_I : M_REL_D;
			GRP_DIR_RMW:  dec_mode = ind ? M_IND_S : M_DIR_S;
			GRP_IDXS_RMW: dec_mode = ind_idx ? M_INDIDX_S : M_IDX_S;
			GRP_IDX0_RMW: dec_mode = M_IDX0;
			GRP_IMM:      dec_mode = M_IMM;
			GRP_DIR_S:    dec_mode = ind ? M_IND_S : M_DIR_S;
			GRP_DIR_L:    dec_mode = ind ? M_IND_L : M_DIR_L;
			GRP_IDX_L:    dec_mode = ind_idx ? M_INDIDX_L : M_IDX_L;
			GRP_IDX_S:    dec_mode = ind_idx ? M_INDIDX_S : M_IDX_S;
			GRP_IDX0:     dec_mode = M_IDX0;
			default:      dec_mode = M_INH;
		endcase
	endfunction

	function automatic logic bad_prebyte(input logic [7:0] p, input logic [3:0] h);
		bad_prebyte = 1'b0;
		if (p == SECOND_INDEX_PREBYTE) begin
			bad_prebyte = (h == GRP_BIT_REL) || (h == GRP_BIT)
				|| (h == GRP_REL);
		end else if (p == SECOND_INDIRECT_PREBYTE) begin
			bad_prebyte = !((h == GRP_IDXS_RMW) || (h == GRP_IDX_L) || (h == GRP_IDX_S));
		end else if (p == INDIRECT_PREBYTE) begin
			bad_prebyte = (h > GRP_DIR_RMW) && (h != GRP_IDXS_RMW) && (h != GRP_DIR_S)
				&& (h != GRP_DIR_L) && (h != GRP_IDX_L) && (h != GRP_IDX_S);
		end
	endfunction

	function automatic logic [1:0] op_bytes(input oamd_mode_t m);
		case (m)
			M_INH, M_IDX0:           op_bytes = 2'd0;
			M_DIR_L, M_IDX_L:        op_bytes = 2'd2;
			M_BITREL_D, M_BITREL_I:  op_bytes = 2'd2;
			default:                 op_bytes = 2'd1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Internal state
	// ----------------------------------------------------------------
	oamd_state_t st_q;
	oamd_mode_t  mode_q;
	oamd_mode_t  dec_m;
	logic        wt_q;
	logic [15:0] pc_q;
	logic [15:0] pc0_q;
	logic [7:0]  pre_q;
	logic [7:0]  opc_q;
	logic [7:0]  x_q;
	logic [7:0]  y_q;
	logic [7:0]  ptr_q;
	logic [7:0]  off_q;
	logic [15:0] base_q;
	logic        ysel_q;
	logic        bad_q;
	logic        is_pre;
	logic        indexed;
	logic [7:0]  idx_val;
	logic [15:0] len_full;
	logic [7:0]  d;

	assign d        = mem_rdata_i;
	assign dec_m    = dec_mode(pre_q, d);
	assign is_pre   = (d == SECOND_INDEX_PREBYTE) || (d == SECOND_INDIRECT_PREBYTE)
		|| (d == INDIRECT_PREBYTE);
	assign indexed  = (mode_q == M_IDX0) || (mode_q == M_IDX_S) || (mode_q == M_IDX_L)
		|| (mode_q == M_INDIDX_S) || (mode_q == M_INDIDX_L);
	assign idx_val  = ysel_q ? y_q : x_q;
	assign len_full = pc_q - pc0_q;

	// ----------------------------------------------------------------
	// Fetch sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q       <= ST_IDLE;
			wt_q       <= 1'b0;
			mem_rd_o   <= 1'b0;
			mem_addr_o <= RESET_PC;
			pc_q       <= RESET_PC;
			pc0_q      <= RESET_PC;
			pre_q      <= 8'h00;
			opc_q      <= 8'h00;
			mode_q     <= M_INH;
			x_q        <= 8'h00;
			y_q        <= 8'h00;
			ptr_q      <= 8'h00;
			off_q      <= 8'h00;
			base_q     <= 16'h0000;
			ysel_q     <= 1'b0;
			bad_q      <= 1'b0;
		end else begin
			mem_rd_o <= 1'b0;
			if (st_q != ST_IDLE && st_q != ST_DONE && wt_q) begin
				wt_q <= 1'b0;
			end else begin
				unique case (st_q)
					ST_IDLE: begin
						if (start_i) begin
							pc_q       <= pc_i;
							pc0_q      <= pc_i;
							pre_q      <= 8'h00;
							x_q        <= x_i;
							y_q        <= y_i;
							base_q     <= 16'h0000;
							off_q      <= 8'h00;
							mem_rd_o   <= 1'b1;
							mem_addr_o <= pc_i;
							wt_q       <= 1'b1;
							st_q       <= ST_OPC;
						end
					end
					ST_OPC: begin
						pc_q <= pc_q + 16'h0001;
						if (pre_q == 8'h00 && is_pre) begin
							pre_q      <= d;
							mem_rd_o   <= 1'b1;
							mem_addr_o <= pc_q + 16'h0001;
							wt_q       <= 1'b1;
						end else begin
							opc_q  <= d;
							mode_q <= dec_m;
							ysel_q <= (pre_q == SECOND_INDEX_PREBYTE)
								|| (pre_q == SECOND_INDIRECT_PREBYTE);
							bad_q  <= bad_prebyte(pre_q, d[7:4]);
							if (op_bytes(dec_m) == 2'd0) begin
								st_q <= ST_DONE;
							end else begin
								mem_rd_o   <= 1'b1;
								mem_addr_o <= pc_q + 16'h0001;
								wt_q       <= 1'b1;
								st_q       <= ST_OP1;
							end
						end
					end
					ST_OP1: begin
						pc_q  <= pc_q + 16'h0001;
						ptr_q <= d;
						case (mode_q)
							M_DIR_L, M_IDX_L: begin
								base_q[15:8] <= d;
								mem_rd_o     <= 1'b1;
								mem_addr_o   <= pc_q + 16'h0001;
								wt_q         <= 1'b1;
								st_q         <= ST_OP2;
							end
							M_BITREL_D: begin
								base_q     <= {PAGE_ZERO_HI, d};
								mem_rd_o   <= 1'b1;
								mem_addr_o <= pc_q + 16'h0001;
								wt_q       <= 1'b1;
								st_q       <= ST_OP2;
							end
							M_IND_S, M_IND_L, M_INDIDX_S, M_INDIDX_L,
							M_REL_I, M_BIT_I, M_BITREL_I: begin
								mem_rd_o   <= 1'b1;
								mem_addr_o <= {PAGE_ZERO_HI, d};
								wt_q       <= 1'b1;
								st_q       <= ST_PT1;
							end
							default: begin
								base_q <= {PAGE_ZERO_HI, d};
								off_q  <= d;
								st_q   <= ST_DONE;
							end
						endcase
					end
					ST_OP2: begin
						pc_q <= pc_q + 16'h0001;
						if (mode_q == M_DIR_L || mode_q == M_IDX_L) begin
							base_q[7:0] <= d;
						end else begin
							off_q <= d;
						end
						st_q <= ST_DONE;
					end
					ST_PT1: begin
						if (mode_q == M_REL_I) begin
							off_q <= d;
							st_q  <= ST_DONE;
						end else if (mode_q == M_IND_L || mode_q == M_INDIDX_L) begin
							base_q[15:8] <= d;
							mem_rd_o     <= 1'b1;
							mem_addr_o   <= {PAGE_ZERO_HI, ptr_q + 8'h01};
							wt_q         <= 1'b1;
							st_q         <= ST_PT2;
						end else begin
							base_q <= {PAGE_ZERO_HI, d};
							if (mode_q == M_BITREL_I) begin
								mem_rd_o   <= 1'b1;
								mem_addr_o <= pc_q;
								wt_q       <= 1'b1;
								st_q       <= ST_OP2;
							end else begin
								st_q <= ST_DONE;
							end
						end
					end
					ST_PT2: begin
						base_q[7:0] <= d;
						st_q        <= ST_DONE;
					end
					ST_DONE: begin
						st_q <= ST_IDLE;
					end
					default: begin
						st_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Results
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_o         <= 1'b0;
			done_o         <= 1'b0;
			mode_o         <= M_INH;
			opcode_o       <= 8'h00;
			operand_o      <= 8'h00;
			ea_o           <= 16'h0000;
			target_o       <= 16'h0000;
			next_pc_o      <= RESET_PC;
			length_o       <= 3'h0;
			second_index_o <= 1'b0;
			illegal_o      <= 1'b0;
		end else begin
			busy_o <= (st_q == ST_IDLE) ? start_i : (st_q != ST_DONE);
			done_o <= (st_q == ST_DONE);
			if (st_q == ST_DONE) begin
				mode_o         <= mode_q;
				opcode_o       <= opc_q;
				operand_o      <= off_q;
				ea_o           <= base_q + (indexed ? {8'h00, idx_val} : 16'h0000);
				target_o       <= pc_q + {{8{off_q[7]}}, off_q};
				next_pc_o      <= pc_q;
				length_o       <= len_full[2:0];
				second_index_o <= ysel_q;
				illegal_o      <= bad_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt mask level
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_mask_o <= IRQ_MASK_RST;
		end else if (st_q == ST_DONE && pre_q == 8'h00) begin
			if (opc_q == SET_IRQ_MASK_OP) begin
				irq_mask_o <= IRQ_MASK_SET_LVL;
			end else if (opc_q == CLEAR_IRQ_MASK_OP) begin
				irq_mask_o <= IRQ_MASK_CLR_LVL;
			end
		end
	end

endmodule // oamd_decoder

/* shared/oamd_pkg.sv */
// Constants and types of the operand address mode decoder.
// Assumes one clock domain and a memory with one cycle of read latency.

package oamd_pkg;

	// ----------------------------------------------------------------
	// Prebytes and flag operations
	// ----------------------------------------------------------------
	localparam logic [7:0] SECOND_INDEX_PREBYTE    = 8'h90;
	localparam logic [7:0] SECOND_INDIRECT_PREBYTE = 8'h91;
	localparam logic [7:0] INDIRECT_PREBYTE        = 8'h92;
	localparam logic [7:0] SET_IRQ_MASK_OP         = 8'h9B;
	localparam logic [7:0] CLEAR_IRQ_MASK_OP       = 8'h9A;
	localparam logic [1:0] IRQ_MASK_SET_LVL        = 2'h3;
	localparam logic [1:0] IRQ_MASK_CLR_LVL        = 2'h0;
	localparam logic [1:0] IRQ_MASK_RST            = 2'h3;

	// ----------------------------------------------------------------
	// Opcode groups, selected by the upper opcode nibble
	// ----------------------------------------------------------------
	localparam logic [3:0] GRP_BIT_REL   = 4'h0;
	localparam logic [3:0] GRP_BIT       = 4'h1;
	localparam logic [3:0] GRP_REL       = 4'h2;
	localparam logic [3:0] GRP_DIR_RMW   = 4'h3;
	localparam logic [3:0] GRP_IDXS_RMW  = 4'h6;
	localparam logic [3:0] GRP_IDX0_RMW  = 4'h7;
	localparam logic [3:0] GRP_IMM       = 4'hA;
	localparam logic [3:0] GRP_DIR_S     = 4'hB;
	localparam logic [3:0] GRP_DIR_L     = 4'hC;
	localparam logic [3:0] GRP_IDX_L     = 4'hD;
	localparam logic [3:0] GRP_IDX_S     = 4'hE;
	localparam logic [3:0] GRP_IDX0      = 4'hF;

	// ----------------------------------------------------------------
	// Address formation
	// ----------------------------------------------------------------
	localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
	localparam logic [15:0] RESET_PC     = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		M_INH      = 5'h00,
		M_IMM      = 5'h01,
		M_DIR_S    = 5'h02,
		M_DIR_L    = 5'h03,
		M_IDX0     = 5'h04,
		M_IDX_S    = 5'h05,
		M_IDX_L    = 5'h06,
		M_IND_S    = 5'h07,
		M_IND_L    = 5'h08,
		M_INDIDX_S = 5'h09,
		M_INDIDX_L = 5'h0A,
		M_REL_D    = 5'h0B,
		M_REL_I    = 5'h0C,
		M_BIT_D    = 5'h0D,
		M_BIT_I    = 5'h0E,
		M_BITREL_D = 5'h0F,
		M_BITREL_I = 5'h10
	} oamd_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_OPC  = 3'h1,
		ST_OP1  = 3'h2,
		ST_OP2  = 3'h3,
		ST_PT1  = 3'h4,
		ST_PT2  = 3'h5,
		ST_DONE = 3'h6
	} oamd_state_t;

endpackage

/* tb/oamd_mem_model.sv */
// Program and data memory model behind the decoder's read port.
// Assumes reads are spaced two cycles apart and answered one cycle later.
`timescale 1ns/1ps

module oamd_mem_model (
	// Clock
	input  wire logic        clk_i,
	// Read port
	input  wire logic        mem_rd_i,
	input  wire logic [15:0] mem_addr_i,
	output logic      [7:0]  mem_rdata_o
);
	logic [7:0] mem [0:65535];

	initial begin
		mem_rdata_o = 8'h00;
		for (int a = 0; a < 65536; a++) begin
			mem[a] = a[7:0] ^ 8'h5A;
		end
	end

	// Data is valid only in the cycle after the strobe; it toggles otherwise.
	always @(posedge clk_i) begin
		if (mem_rd_i) begin
			mem_rdata_o <= mem[mem_addr_i];
		end else begin
			mem_rdata_o <= ~mem_rdata_o;
		end
	end
endmodule // oamd_mem_model

/* tb/oamd_properties.sv */
// Concurrent checks on the decoder's ports.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps

module oamd_properties
	import oamd_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	// Request
	input wire logic        start_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0]  x_i,
	input wire logic [7:0]  y_i,
	// Memory
	input wire logic        mem_rd_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic [7:0]  mem_rdata_i,
	// Result
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic [4:0]  mode_o,
	input wire logic [7:0]  opcode_o,
	input wire logic [7:0]  operand_o,
	input wire logic [15:0] ea_o,
	input wire logic [15:0] target_o,
	input wire logic [15:0] next_pc_o,
	input wire logic [2:0]  length_o,
	input wire logic        second_index_o,
	input wire logic        illegal_o,
	input wire logic [1:0]  irq_mask_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	logic [15:0] pc_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pc_q <= 16'h0000;
		end else if (start_i && !busy_o) begin
			pc_q <= pc_i;
		end
	end

	property p_first_fetch;
		start_i && !busy_o |=> mem_rd_o && busy_o && mem_addr_o == $past(pc_i);
	endproperty
	a_first_fetch: assert property (p_first_fetch) else $error("first fetch wrong");
	property p_rd_space;
		mem_rd_o |=> !mem_rd_o;
	endproperty
	a_rd_space: assert property (p_rd_space) else $error("reads too close");
	property p_next_pc;
		done_o |-> next_pc_o == pc_q + 16'(length_o);
	endproperty
	a_next_pc: assert property (p_next_pc) else $error("next pc wrong");
	property p_inh_len;
		done_o && mode_o == M_INH && !second_index_o && !illegal_o |-> length_o == 3'h1;
	endproperty
	a_inh_len: assert property (p_inh_len) else $error("inherent length");
	property p_imm_len;
		done_o && mode_o == M_IMM && !second_index_o && !illegal_o |-> length_o == 3'h2;
	endproperty
	a_imm_len: assert property (p_imm_len) else $error("immediate length");
	property p_dir_s;
		done_o && mode_o == M_DIR_S |-> ea_o[15:8] == 8'h00;
	endproperty
	a_dir_s: assert property (p_dir_s) else $error("short direct range");
	property p_idx0;
		done_o && mode_o == M_IDX0 |-> ea_o[15:8] == 8'h00;
	endproperty
	a_idx0: assert property (p_idx0) else $error("no-offset range");
	property p_idx_s;
		done_o && (mode_o == M_IDX_S || mode_o == M_INDIDX_S) |-> ea_o <= 16'h01FE;
	endproperty
	a_idx_s: assert property (p_idx_s) else $error("short indexed range");
	property p_ind_s;
		done_o && mode_o == M_IND_S |-> ea_o[15:8] == 8'h00 && length_o == 3'h3;
	endproperty
	a_ind_s: assert property (p_ind_s) else $error("short indirect");
	property p_rel;
		done_o && mode_o == M_REL_D |-> target_o == next_pc_o + {{8{operand_o[7]}}, operand_o};
	endproperty
	a_rel: assert property (p_rel) else $error("relative target");
	property p_sim;
		done_o && opcode_o == SET_IRQ_MASK_OP && length_o == 3'h1 |-> ##[0:1] irq_mask_o == 2'h3;
	endproperty
	a_sim: assert property (p_sim) else $error("mask not set");
	property p_done;
		done_o && !start_i |=> !done_o && !busy_o;
	endproperty
	a_done: assert property (p_done) else $error("done not a pulse");

	c_ind: cover property (done_o && mode_o == M_INDIDX_L);
	c_rel: cover property (done_o && mode_o == M_REL_D);
	c_b2b: cover property (done_o && start_i);
endmodule // oamd_properties

bind oamd_decoder oamd_properties u_oamd_properties (
	.clk_i          (clk_i),
	.arst_n_i       (arst_n_i),
	.start_i        (start_i),
	.pc_i           (pc_i),
	.x_i            (x_i),
	.y_i            (y_i),
	.mem_rd_o       (mem_rd_o),
	.mem_addr_o     (mem_addr_o),
	.mem_rdata_i    (mem_rdata_i),
	.busy_o         (busy_o),
	.done_o         (done_o),
	.mode_o         (mode_o),
	.opcode_o       (opcode_o),
	.operand_o      (operand_o),
	.ea_o           (ea_o),
	.target_o       (target_o),
	.next_pc_o      (next_pc_o),
	.length_o       (length_o),
	.second_index_o (second_index_o),
	.illegal_o      (illegal_o),
	.irq_mask_o     (irq_mask_o)
);

/* tb/tb.sv */
// Self-checking bench for the operand address mode decoder.
// Assumes the memory model answers every read one cycle later.
`timescale 1ns/1ps

module tb;
	import oamd_pkg::*;

	logic clk_i = 1'b0, arst_n_i = 1'b0, start_i = 1'b0, mem_rd_o, busy_o, done_o;
	logic second_index_o, illegal_o;
	logic [15:0] pc_i = 16'h0000, mem_addr_o, ea_o, target_o, next_pc_o;
	logic [7:0]  x_i = 8'h00, y_i = 8'h00, mem_rdata_i, opcode_o, operand_o;
	logic [4:0]  mode_o;
	logic [2:0]  length_o;
	logic [1:0]  irq_mask_o;
	int          fail_count = 0, tests_run = 0;

	always #20 clk_i = ~clk_i;

	oamd_decoder u_oamd_decoder (
		.clk_i          (clk_i),
		.arst_n_i       (arst_n_i),
		.start_i        (start_i),
		.pc_i           (pc_i),
		.x_i            (x_i),
		.y_i            (y_i),
		.mem_rd_o       (mem_rd_o),
		.mem_addr_o     (mem_addr_o),
		.mem_rdata_i    (mem_rdata_i),
		.busy_o         (busy_o),
		.done_o         (done_o),
		.mode_o         (mode_o),
		.opcode_o       (opcode_o),
		.operand_o      (operand_o),
		.ea_o           (ea_o),
		.target_o       (target_o),
		.next_pc_o      (next_pc_o),
		.length_o       (length_o),
		.second_index_o (second_index_o),
		.illegal_o      (illegal_o),
		.irq_mask_o     (irq_mask_o)
	);
	oamd_mem_model u_oamd_mem_model (.clk_i(clk_i), .mem_rd_i(mem_rd_o),
		.mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			$display("BAD %0t seen %h expected %h", $time, s, e);
			fail_count++;
		end
	endtask

	task automatic pz(input logic [7:0] a, input logic [7:0] hi, input logic [7:0] lo);
		u_oamd_mem_model.mem[{8'h00, a}] = hi;
		u_oamd_mem_model.mem[{8'h00, a + 8'h01}] = lo;
	endtask

	// Places three bytes at p, decodes them and checks the common results.
	task automatic go(input logic [15:0] p, input logic [7:0] b0, b1, b2, xv, yv,
		input logic [2:0] ln, input logic [15:0] ea, input logic [4:0] md);
		int n;
		u_oamd_mem_model.mem[p] = b0;
		u_oamd_mem_model.mem[p + 16'h0001] = b1;
		u_oamd_mem_model.mem[p + 16'h0002] = b2;
		pc_i = p;
		x_i = xv;
		y_i = yv;
		start_i = 1'b1;
		@(posedge clk_i);
		#1 start_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			#1 n++;
		end
		if (n >= 40) begin
			fail_count++;
			tally_and_finish();
		end
		chk(16'(length_o), 16'(ln));
		chk(next_pc_o, p + 16'(ln));
		chk(16'(mode_o), 16'(md));
		if (md > M_IMM && md != M_REL_D && md != M_REL_I) begin
			chk(ea_o, ea);
		end
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		chk(16'(irq_mask_o), 16'(IRQ_MASK_RST));
		#1 arst_n_i = 1'b1;
		go(16'h0200, 8'h9D, 8'h00, 8'h00, 8'h00, 8'h00, 3'h1, 16'h0, M_INH);
		go(16'h0210, 8'hA6, 8'h55, 8'h00, 8'h00, 8'h00, 3'h2, 16'h0, M_IMM);
		chk(16'(operand_o), 16'h0055);
		chk(16'(opcode_o), 16'h00A6);
		go(16'h0220, 8'hB6, 8'h10, 8'h00, 8'h00, 8'h00, 3'h2, 16'h0010, M_DIR_S);
		go(16'h0230, 8'hC6, 8'h12, 8'h34, 8'h00, 8'h00, 3'h3, 16'h1234, M_DIR_L);
		go(16'h0240, 8'hF6, 8'h00, 8'h00, 8'hFF, 8'h00, 3'h1, 16'h00FF, M_IDX0);
		go(16'h0250, 8'hE6, 8'hFF, 8'h00, 8'hFF, 8'h00, 3'h2, 16'h01FE, M_IDX_S);
		go(16'h0260, 8'hD6, 8'h12, 8'h00, 8'h34, 8'h00, 3'h3, 16'h1234, M_IDX_L);
		go(16'h0270, 8'h90, 8'hE6, 8'h10, 8'h00, 8'h20, 3'h3, 16'h0030, M_IDX_S);
		chk(16'(second_index_o), 16'h0001);
		pz(8'h10, 8'h40, 8'h00);
		go(16'h0280, 8'h92, 8'hB6, 8'h10, 8'h00, 8'h00, 3'h3, 16'h0040, M_IND_S);
		pz(8'h10, 8'h12, 8'h34);
		go(16'h0290, 8'h92, 8'hC6, 8'h10, 8'h00, 8'h00, 3'h3, 16'h1234, M_IND_L);
		pz(8'hFF, 8'hFF, 8'h00);
		go(16'h02A0, 8'h92, 8'hE6, 8'hFF, 8'hFF, 8'h00, 3'h3, 16'h01FE, M_INDIDX_S);
		go(16'h02B0, 8'h91, 8'hD6, 8'h10, 8'h00, 8'h01, 3'h3, 16'h1235, M_INDIDX_L);
		go(16'h02C0, 8'h20, 8'hFE, 8'h00, 8'h00, 8'h00, 3'h2, 16'h0, M_REL_D);
		chk(target_o, 16'h02C0);
		go(16'h02D0, 8'h90, 8'hB6, 8'h10, 8'h00, 8'h00, 3'h3, 16'h0010, M_DIR_S);
		chk(16'(illegal_o), 16'h0000);
		chk(16'(second_index_o), 16'h0001);
		go(16'h02D8, 8'h91, 8'hB6, 8'h10, 8'h00, 8'h00, 3'h3, 16'h0010, M_DIR_S);
		chk(16'(illegal_o), 16'h0001);
		go(16'h0300, 8'h3C, 8'h20, 8'h00, 8'h00, 8'h00, 3'h2, 16'h0020, M_DIR_S);
		go(16'h0310, 8'h00, 8'h10, 8'h05, 8'h00, 8'h00, 3'h3, 16'h0010, M_BITREL_D);
		chk(target_o, 16'h0318);
		go(16'h0320, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00, 3'h2, 16'h0020, M_BIT_D);
		pz(8'h30, 8'hFB, 8'h00);
		go(16'h0330, 8'h92, 8'h20, 8'h30, 8'h00, 8'h00, 3'h3, 16'h0, M_REL_I);
		chk(target_o, 16'h032E);
		pz(8'h40, 8'h55, 8'h00);
		go(16'h0340, 8'h92, 8'h10, 8'h40, 8'h00, 8'h00, 3'h3, 16'h0055, M_BIT_I);
		u_oamd_mem_model.mem[16'h0353] = 8'h07;
		go(16'h0350, 8'h92, 8'h00, 8'h40, 8'h00, 8'h00, 3'h4, 16'h0055, M_BITREL_I);
		chk(target_o, 16'h035B);
		go(16'h02E0, 8'h9A, 8'h00, 8'h00, 8'h00, 8'h00, 3'h1, 16'h0, M_INH);
		@(posedge clk_i);
		#1 chk(16'(irq_mask_o), 16'(IRQ_MASK_CLR_LVL));
		go(16'h02F0, 8'h9B, 8'h00, 8'h00, 8'h00, 8'h00, 3'h1, 16'h0, M_INH);
		@(posedge clk_i);
		#1 chk(16'(irq_mask_o), 16'(IRQ_MASK_SET_LVL));
		tally_and_finish();
	end
endmodule // tb
